// ==== rtl/swk_sequencer_defines.vh ====
// Constants for the suspend and wake sequencer
//
// What this block does
// - One selected clock times every wake step
// - Wake clock select defaults to internal oscillator
// - Sources: oscillator, config clock, test clock, user
// - Oscillator stays off throughout suspend
// - Output release count 1..1024, default four
// - Release counts after status high, frees outputs
// - Write unlock count 1..1024, default five
// - Unlock expiry lifts write protection everywhere
// - Optional global reset before unlock, else keep
// - Test port, done, reprogram pins keep working
// - High request pin enters suspend, maybe after ack
// - Request falling starts wake, monitor pins too
// - Feature disabled ignores the request pin
// - Status pin low suspended, high active
// - Handshake raises request next edge, waits ack
// - Status held low stalls both wake counters
`ifndef SWK_SEQUENCER_DEFINES_VH
`define SWK_SEQUENCER_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SWK_ADDR_CONFIG 8'h00
`define SWK_ADDR_OUT_RELEASE 8'h04
`define SWK_ADDR_WRITE_UNLOCK 8'h08
`define SWK_ADDR_WAKE_MASK 8'h0C
`define SWK_ADDR_STATUS 8'h10

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define SWK_CFG_ENABLE 0
`define SWK_CFG_WAKE_CLK 1
`define SWK_CFG_STARTUP_LO 2
`define SWK_CFG_STARTUP_HI 3
`define SWK_CFG_GSR 4
`define SWK_CFG_HANDSHAKE 5
`define SWK_CFG_MONITOR 6
`define SWK_CFG_WIDTH 7
`define SWK_RST_CONFIG 7'h00

// Startup clock choices
`define SWK_STARTUP_CCLK 2'h0
`define SWK_STARTUP_TCK 2'h1
`define SWK_STARTUP_USER 2'h2

// Wake clock source indices
`define SWK_SRC_OSC 0
`define SWK_SRC_CCLK 1
`define SWK_SRC_TCK 2
`define SWK_SRC_USER 3
`define SWK_SRC_COUNT 4

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define SWK_CNT_WIDTH 11
`define SWK_CNT_MIN 11'h001
`define SWK_CNT_MAX 11'h400
`define SWK_RST_OUT_RELEASE 11'h004
`define SWK_RST_WRITE_UNLOCK 11'h005
`define SWK_MON_WIDTH 8
`define SWK_RST_WAKE_MASK 8'hFF
`define SWK_OSC_MHZ 50

`endif

// ==== rtl/swk_wake_counter.v ====
// Wake counter that flags expiry after a programmed number of ticks
`timescale 1ns/1ps
`default_nettype none
`include "swk_sequencer_defines.vh"

module swk_wake_counter (
    input wire clk,
    input wire resetn,
    input wire clear,
    input wire run,
    input wire tick,
    input wire [`SWK_CNT_WIDTH-1:0] limit,
    output reg done
);

    reg [`SWK_CNT_WIDTH-1:0] count;
    wire [`SWK_CNT_WIDTH-1:0] next_count;

    // Count one step ahead so expiry lands on the limit-th tick
    assign next_count = count + `SWK_CNT_MIN;

    // Clear on entry, count ticks only while running
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= {`SWK_CNT_WIDTH{1'b0}};
            done <= 1'b0;
        end else if (clear) begin
            count <= {`SWK_CNT_WIDTH{1'b0}};
            done <= 1'b0;
        end else if (run && tick && !done) begin
            count <= next_count;
            if (next_count >= limit) begin
                done <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ==== rtl/swk_sequencer.v ====
// Suspend entry and timed wake sequencer with its register port
`timescale 1ns/1ps
`default_nettype none
`include "swk_sequencer_defines.vh"

module swk_sequencer (
    input wire clk,
    input wire resetn,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [31:0] reg_rdata,
    input wire suspend_pin,
    input wire awake_in,
    output reg awake_out,
    output reg awake_oe,
    output reg sleep_request_out,
    input wire sleep_ack_in,
    input wire [`SWK_MON_WIDTH-1:0] wake_monitor_pins,
    input wire osc_clk,
    input wire cclk_pin,
    input wire tck_pin,
    input wire user_clk,
    output reg osc_enable,
    output reg outputs_released,
    output reg write_enable,
    output reg global_reset,
    output reg test_port_active,
    output reg suspended
);

    // ----------------------------------------------------------------
    // State codes
    // ----------------------------------------------------------------
    localparam [2:0] ST_ACTIVE = 3'h0;
    localparam [2:0] ST_REQUEST = 3'h1;
    localparam [2:0] ST_SUSPEND = 3'h2;
    localparam [2:0] ST_RESET = 3'h3;
    localparam [2:0] ST_WAKE = 3'h4;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg [2:0] state;
    reg [2:0] next_state;
    reg [`SWK_CFG_WIDTH-1:0] config_reg;
    reg [`SWK_CNT_WIDTH-1:0] output_release_count;
    reg [`SWK_CNT_WIDTH-1:0] write_unlock_count;
    reg [`SWK_MON_WIDTH-1:0] wake_mask;
    reg suspend_meta;
    reg suspend_sync;
    reg awake_meta;
    reg awake_sync;
    reg [`SWK_MON_WIDTH-1:0] mon_meta;
    reg [`SWK_MON_WIDTH-1:0] mon_sync;
    reg counters_clear;
    reg wake_tick;
    wire [`SWK_SRC_COUNT-1:0] src_raw;
    wire [`SWK_SRC_COUNT-1:0] src_tick;
    wire suspend_enable;
    wire wake_clock_select;
    wire [1:0] startup_clock_select;
    wire wake_global_reset_enable;
    wire handshake_present;
    wire monitor_enable;
    wire monitor_ok;
    wire release_done;
    wire unlock_done;
    wire counting;
    wire [`SWK_CNT_WIDTH-1:0] wr_count;
    wire [`SWK_CNT_WIDTH-1:0] clamped_count;
    wire [31:0] status_word;

    // ----------------------------------------------------------------
    // Configuration fields
    // ----------------------------------------------------------------
    assign suspend_enable = config_reg[`SWK_CFG_ENABLE];
    assign wake_clock_select = config_reg[`SWK_CFG_WAKE_CLK];
    assign startup_clock_select =
        config_reg[`SWK_CFG_STARTUP_HI:`SWK_CFG_STARTUP_LO];
    assign wake_global_reset_enable = config_reg[`SWK_CFG_GSR];
    assign handshake_present = config_reg[`SWK_CFG_HANDSHAKE];
    assign monitor_enable = config_reg[`SWK_CFG_MONITOR];

    // Written counts outside 1..1024 are pulled into range
    assign wr_count = reg_wdata[`SWK_CNT_WIDTH-1:0];
    assign clamped_count = (reg_wdata[31:`SWK_CNT_WIDTH] != 21'h0_0000 ||
                            wr_count > `SWK_CNT_MAX) ? `SWK_CNT_MAX :
                           (wr_count < `SWK_CNT_MIN) ? `SWK_CNT_MIN :
                           wr_count;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Software owns configuration, counts and the monitor mask
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            config_reg <= `SWK_RST_CONFIG;
            output_release_count <= `SWK_RST_OUT_RELEASE;
            write_unlock_count <= `SWK_RST_WRITE_UNLOCK;
            wake_mask <= `SWK_RST_WAKE_MASK;
        end else if (reg_write) begin
            case (reg_addr)
                `SWK_ADDR_CONFIG: begin
                    config_reg <= reg_wdata[`SWK_CFG_WIDTH-1:0];
                end
                `SWK_ADDR_OUT_RELEASE: begin
                    output_release_count <= clamped_count;
                end
                `SWK_ADDR_WRITE_UNLOCK: begin
                    write_unlock_count <= clamped_count;
                end
                `SWK_ADDR_WAKE_MASK: begin
                    wake_mask <= reg_wdata[`SWK_MON_WIDTH-1:0];
                end
                default: begin
                    config_reg <= config_reg;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    // Live sequencer state for software to poll
    assign status_word = {22'h00_0000, mon_sync != 8'h00, suspend_sync,
                          awake_sync, sleep_request_out, osc_enable,
                          write_enable, outputs_released, state};

    // Read data stands in the cycle after the strobe only
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            case (reg_addr)
                `SWK_ADDR_CONFIG: begin
                    reg_rdata <= {25'h000_0000, config_reg};
                end
                `SWK_ADDR_OUT_RELEASE: begin
                    reg_rdata <= {21'h0_0000, output_release_count};
                end
                `SWK_ADDR_WRITE_UNLOCK: begin
                    reg_rdata <= {21'h0_0000, write_unlock_count};
                end
                `SWK_ADDR_WAKE_MASK: begin
                    reg_rdata <= {24'h00_0000, wake_mask};
                end
                `SWK_ADDR_STATUS: begin
                    reg_rdata <= status_word;
                end
                default: begin
                    reg_rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Request, status and monitor pins pass two flops first
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            suspend_meta <= 1'b0;
            suspend_sync <= 1'b0;
            awake_meta <= 1'b0;
            awake_sync <= 1'b0;
            mon_meta <= 8'h00;
            mon_sync <= 8'h00;
        end else begin
            suspend_meta <= suspend_pin;
            suspend_sync <= suspend_meta;
            awake_meta <= awake_in;
            awake_sync <= awake_meta;
            mon_meta <= wake_monitor_pins;
            mon_sync <= mon_meta;
        end
    end

    // Wake also needs a high on some unmasked monitor pin when in use
    assign monitor_ok = !monitor_enable || ((mon_sync & wake_mask) != 8'h00);

    // ----------------------------------------------------------------
    // Wake clock sources
    // ----------------------------------------------------------------
    assign src_raw[`SWK_SRC_OSC] = osc_clk;
    assign src_raw[`SWK_SRC_CCLK] = cclk_pin;
    assign src_raw[`SWK_SRC_TCK] = tck_pin;
    assign src_raw[`SWK_SRC_USER] = user_clk;

    // Each source is synchronised, then its rising edge becomes a tick
    genvar gi;
    generate
        for (gi = 0; gi < `SWK_SRC_COUNT; gi = gi + 1) begin : g_src
            reg [2:0] sh;
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    sh <= 3'h0;
                end else begin
                    sh <= {sh[1:0], src_raw[gi]};
                end
            end
            // Edge taken from the second and third flops only
            assign src_tick[gi] = sh[1] & ~sh[2];
        end
    endgenerate

    // One selected source times every wake step
    always @* begin
        wake_tick = 1'b0;
        if (!wake_clock_select) begin
            wake_tick = src_tick[`SWK_SRC_OSC];
        end else begin
            case (startup_clock_select)
                `SWK_STARTUP_CCLK: begin
                    wake_tick = src_tick[`SWK_SRC_CCLK];
                end
                `SWK_STARTUP_TCK: begin
                    wake_tick = src_tick[`SWK_SRC_TCK];
                end
                default: begin
                    wake_tick = src_tick[`SWK_SRC_USER];
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Wake counters
    // ----------------------------------------------------------------
    // Counting runs only once the status pin reads high
    assign counting = (state == ST_WAKE) && awake_sync;

    swk_wake_counter u_release_counter (
        .clk(clk),
        .resetn(resetn),
        .clear(counters_clear),
        .run(counting),
        .tick(wake_tick),
        .limit(output_release_count),
        .done(release_done)
    );

    swk_wake_counter u_unlock_counter (
        .clk(clk),
        .resetn(resetn),
        .clear(counters_clear),
        .run(counting),
        .tick(wake_tick),
        .limit(write_unlock_count),
        .done(unlock_done)
    );

    // ----------------------------------------------------------------
    // Sequencer state machine
    // ----------------------------------------------------------------
    // Next state from request pin, handshake and counter expiry
    always @* begin
        next_state = state;
        case (state)
            ST_ACTIVE: begin
                if (suspend_enable && suspend_sync) begin
                    next_state = handshake_present ? ST_REQUEST :
                                 ST_SUSPEND;
                end
            end
            ST_REQUEST: begin
                if (!suspend_sync) begin
                    next_state = ST_ACTIVE;
                end else if (sleep_request_out && sleep_ack_in) begin
                    next_state = ST_SUSPEND;
                end
            end
            ST_SUSPEND: begin
                if (!suspend_sync && monitor_ok) begin
                    next_state = wake_global_reset_enable ? ST_RESET :
                                 ST_WAKE;
                end
            end
            ST_RESET: begin
                next_state = ST_WAKE;
            end
            ST_WAKE: begin
                if (release_done && unlock_done) begin
                    next_state = ST_ACTIVE;
                end
            end
            default: begin
                next_state = ST_ACTIVE;
            end
        endcase
    end

    // State register and counter clear on entry into suspend
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_ACTIVE;
            counters_clear <= 1'b1;
        end else begin
            state <= next_state;
            counters_clear <= (next_state == ST_SUSPEND) &&
                              (state != ST_SUSPEND);
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Every output is a flop; release and unlock follow the current wake state
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            awake_out <= 1'b0;
            awake_oe <= 1'b0;
            sleep_request_out <= 1'b0;
            osc_enable <= 1'b1;
            outputs_released <= 1'b1;
            write_enable <= 1'b1;
            global_reset <= 1'b0;
            test_port_active <= 1'b1;
            suspended <= 1'b0;
        end else begin
            // Open drain: only ever pulls low
            awake_out <= 1'b0;
            // Pulled low while suspended or resetting, else released
            awake_oe <= suspend_enable && ((next_state == ST_SUSPEND) ||
                        (next_state == ST_RESET));
            sleep_request_out <= (next_state == ST_REQUEST);
            osc_enable <= (next_state != ST_SUSPEND);
            suspended <= (next_state == ST_SUSPEND);
            // Pulse global reset ahead of the status pin rising
            global_reset <= (next_state == ST_RESET);
            // Test port and configuration pins never suspend
            test_port_active <= 1'b1;
            if (next_state == ST_SUSPEND) begin
                outputs_released <= 1'b0;
                write_enable <= 1'b0;
            end else if (state == ST_WAKE) begin
                if (release_done) begin
                    outputs_released <= 1'b1;
                end
                if (unlock_done) begin
                    write_enable <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ==== dv/swk_sequencer_asserts.sv ====
// Port checker of the suspend and wake sequencer
`timescale 1ns/1ps
`default_nettype none
module swk_sequencer_asserts (
    input wire clk,
    input wire resetn,
    input wire suspend_pin,
    input wire awake_in,
    input wire awake_out,
    input wire awake_oe,
    input wire sleep_request_out,
    input wire sleep_ack_in,
    input wire osc_enable,
    input wire outputs_released,
    input wire write_enable,
    input wire global_reset,
    input wire test_port_active,
    input wire suspended
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // Suspend state outputs
    // ------------------------------------------------------------
    osc_off_a: assert property (suspended |-> !osc_enable)
        else $error("oscillator running while suspended");
    awake_drive_a: assert property (suspended |-> awake_oe && !awake_out)
        else $error("status wire not pulled low in suspend");
    test_port_a: assert property (test_port_active)
        else $error("test port not active");
    suspend_lock_a: assert property (
        suspended |-> !outputs_released && !write_enable)
        else $error("outputs or writes free while suspended");
    // Pin passes two sync flops, then the state decision, then the flop
    entry_cause_a: assert property (
        $rose(suspended) |-> $past(suspend_pin, 3))
        else $error("suspend entered without request pin");
    ack_wait_a: assert property (
        sleep_request_out && !sleep_ack_in && !suspended |=> !suspended)
        else $error("suspend entered without acknowledge");

    // ------------------------------------------------------------
    // Wake sequence
    // ------------------------------------------------------------
    // Global reset step delays the status release by one more cycle
    wake_cause_a: assert property (
        $fell(awake_oe) |-> ($past(global_reset) ? !$past(suspend_pin, 4) :
                             !$past(suspend_pin, 3)))
        else $error("wake started with request pin high");
    // Expiry tick used the status level seen through two sync flops
    release_stall_a: assert property (
        $rose(outputs_released) |-> $past(awake_in, 4))
        else $error("outputs released while status held low");
    gsr_window_a: assert property (
        global_reset |-> awake_oe && !write_enable && !outputs_released)
        else $error("global reset outside the wake window");
endmodule

bind swk_sequencer swk_sequencer_asserts swk_sequencer_asserts_inst (
    .clk(clk),
    .resetn(resetn),
    .suspend_pin(suspend_pin),
    .awake_in(awake_in),
    .awake_out(awake_out),
    .awake_oe(awake_oe),
    .sleep_request_out(sleep_request_out),
    .sleep_ack_in(sleep_ack_in),
    .osc_enable(osc_enable),
    .outputs_released(outputs_released),
    .write_enable(write_enable),
    .global_reset(global_reset),
    .test_port_active(test_port_active),
    .suspended(suspended)
);
`default_nettype wire

// ==== dv/swk_system_partner.sv ====
// Model of the system controller, status wire and wake clock sources
`timescale 1ns/1ps
`default_nettype none
module swk_system_partner (
    input wire logic clk,
    input wire logic want,
    input wire logic hold,
    input wire logic [3:0] run,
    input wire logic osc_enable,
    input wire logic awake_oe,
    output logic suspend_pin,
    output logic awake_in,
    output logic osc_clk,
    output logic cclk_pin,
    output logic tck_pin,
    output logic user_clk
);
    // Divider starts known; pins settle on the first edge, inside reset
    logic [2:0] div = 3'h0;

    // Pull-up on the status wire, low if either side sinks it
    assign awake_in = !(awake_oe || hold);

    // Request pin high only while suspend is wanted; slow sources
    always @(posedge clk) begin
        suspend_pin <= want;
        div <= div + 3'h1;
        osc_clk <= run[0] & osc_enable & div[2];
        cclk_pin <= run[1] & div[2];
        // Test clock only ticks; no instruction is ever shifted in
        tck_pin <= run[2] & div[2];
        user_clk <= run[3] & div[2];
    end
endmodule
`default_nettype wire

// ==== dv/swk_sequencer_tb.sv ====
// Self-checking bench of the suspend and wake sequencer
`timescale 1ns/1ps
`default_nettype none
`include "swk_sequencer_defines.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
`define WAITC(c) begin n = 0; while ((c) !== 1'b1 && n < 300) begin \
  @(posedge clk); n++; end `CHK((c), 1'b1) end
module swk_sequencer_tb;
    typedef struct packed {
        logic wr;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } swk_row_t;
    reg clk, resetn, reg_write, reg_read, want, hold, sleep_ack_in;
    reg [7:0] reg_addr, mon;
    reg [31:0] reg_wdata;
    reg [3:0] run, src_q;
    reg rel_q, unl_q;
    wire [31:0] reg_rdata;
    wire suspend_pin, awake_in, awake_out, awake_oe, sleep_request_out;
    wire osc_clk, cclk_pin, tck_pin, user_clk, osc_enable, suspended;
    wire outputs_released, write_enable, global_reset, test_port_active;
    wire [3:0] srcs = {user_clk, tck_pin, cclk_pin, osc_clk};
    int bad_count, comparisons, cycles, n, sel, ecnt, rel_cnt, unl_cnt;
    int gsr_cnt, g0;
    // Register rows: write flag, address, write data, expected read
    swk_row_t rows [12] = '{
        '{1'b0, 8'h00, 32'h0, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h4},
        '{1'b0, 8'h08, 32'h0, 32'h5}, '{1'b0, 8'h0C, 32'h0, 32'hFF},
        '{1'b0, 8'h10, 32'h0, 32'hB8}, '{1'b0, 8'h14, 32'h0, 32'h0},
        '{1'b1, 8'h04, 32'h0, 32'h1}, '{1'b1, 8'h08, 32'h7FF, 32'h400},
        '{1'b1, 8'h04, 32'h400, 32'h400}, '{1'b1, 8'h14, 32'h5, 32'h0},
        '{1'b1, 8'h10, 32'hFFFF, 32'hB8}, '{1'b1, 8'h0C, 32'hF, 32'hF}};

    swk_sequencer swk_sequencer_inst (.clk(clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .suspend_pin(suspend_pin), .awake_in(awake_in),
        .awake_out(awake_out), .awake_oe(awake_oe),
        .sleep_request_out(sleep_request_out), .sleep_ack_in(sleep_ack_in),
        .wake_monitor_pins(mon), .osc_clk(osc_clk), .cclk_pin(cclk_pin),
        .tck_pin(tck_pin), .user_clk(user_clk), .osc_enable(osc_enable),
        .outputs_released(outputs_released), .write_enable(write_enable),
        .global_reset(global_reset), .test_port_active(test_port_active),
        .suspended(suspended));
    swk_system_partner swk_system_partner_inst (.clk(clk), .want(want),
        .hold(hold), .run(run), .osc_enable(osc_enable),
        .awake_oe(awake_oe), .suspend_pin(suspend_pin),
        .awake_in(awake_in), .osc_clk(osc_clk), .cclk_pin(cclk_pin),
        .tck_pin(tck_pin), .user_clk(user_clk));

    // ------------------------------------------------------------
    // Clock, edge counting and hang guard
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        src_q <= srcs;
        rel_q <= outputs_released;
        unl_q <= write_enable;
        if (global_reset) gsr_cnt <= gsr_cnt + 1;
        if (!awake_in) ecnt <= 0;
        else if (srcs[sel] && !src_q[sel]) ecnt <= ecnt + 1;
        if (outputs_released && !rel_q) rel_cnt <= ecnt;
        if (write_enable && !unl_q) unl_cnt <= ecnt;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
    endtask
    // One suspend entry and timed wake from the chosen source
    task automatic wake_cycle(input logic [6:0] cfg, input int rel, unl, s);
        reg_wr(`SWK_ADDR_OUT_RELEASE, rel);
        reg_wr(`SWK_ADDR_WRITE_UNLOCK, unl);
        reg_wr(`SWK_ADDR_CONFIG, {25'h0, cfg});
        sel = s;
        run <= 4'h1 << s;
        g0 = gsr_cnt;
        want <= 1'b1;
        if (cfg[5]) begin
            `WAITC(sleep_request_out)
            repeat (4) @(posedge clk);
            `CHK(suspended, 1'b0)
            sleep_ack_in <= 1'b1;
        end
        `WAITC(suspended)
        sleep_ack_in <= 1'b0;
        `CHK({osc_enable, outputs_released, write_enable}, 3'b000)
        `CHK({awake_oe, awake_in}, 2'b10)
        hold <= 1'b1;
        want <= 1'b0;
        if (cfg[6]) begin
            repeat (12) @(posedge clk);
            `CHK(suspended, 1'b1)
            mon <= 8'h01;
        end
        `WAITC(!awake_oe)
        repeat (40) @(posedge clk);
        `CHK({outputs_released, write_enable}, 2'b00)
        hold <= 1'b0;
        `WAITC(outputs_released && write_enable)
        @(posedge clk);
        `CHK(rel_cnt >= rel && rel_cnt <= rel + 1, 1'b1)
        `CHK(unl_cnt >= unl && unl_cnt <= unl + 1, 1'b1)
        `CHK(gsr_cnt != g0, cfg[4])
        `CHK({suspended, osc_enable}, 2'b01)
        run <= 4'h0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {reg_write, reg_read, want, hold, sleep_ack_in} = 5'h0;
        {reg_addr, mon, reg_wdata, run} = 52'h0;
        resetn = 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) reg_wr(rows[i].a, rows[i].d);
            reg_rd(rows[i].a);
            `CHK(reg_rdata, rows[i].e)
        end
        want <= 1'b1;
        repeat (12) @(posedge clk);
        `CHK({suspended, osc_enable, test_port_active}, 3'b011)
        want <= 1'b0;
        repeat (4) @(posedge clk);
        // Every scenario releases outputs before lifting write protection
        wake_cycle(7'h01, 4, 5, `SWK_SRC_OSC);
        wake_cycle(7'h13, 1, 2, `SWK_SRC_CCLK);
        wake_cycle(7'h27, 3, 6, `SWK_SRC_TCK);
        reg_wr(`SWK_ADDR_WAKE_MASK, 32'h1);
        mon <= 8'h02;
        wake_cycle(7'h4B, 2, 3, `SWK_SRC_USER);
        test_done();
    end
endmodule
`default_nettype wire
